/* verilog/ccf_pkg.sv */
// Constants and carrier types for the cluster command frame builder.
// Assumes one byte-wide serial API link and a 32-bit Avalon-MM control port.
package ccf_pkg;

    // Serial API frame layout
    localparam logic [7:0]  START_DELIM    = 8'h7e;
    localparam logic [7:0]  FT_EXPLICIT_TX = 8'h11;
    localparam logic [7:0]  CHK_BASE       = 8'hff;
    localparam logic [7:0]  TX_OPTIONS     = 8'h00;
    localparam logic [7:0]  CMD_READ_ATTR  = 8'h00;
    localparam logic [15:0] NWK_UNKNOWN    = 16'hfffe;
    localparam logic [15:0] LEN_BASE       = 16'h0017;
    localparam logic [5:0]  OFS_LEN_LO     = 6'h02;
    localparam logic [5:0]  OFS_SUM_FIRST  = 6'h03;
    localparam logic [5:0]  OFS_NWK_MSB    = 6'h0d;
    localparam logic [5:0]  OFS_TX_OPT     = 6'h16;
    localparam logic [5:0]  OFS_FCTL       = 6'h17;
    localparam logic [5:0]  OFS_SEQ        = 6'h18;
    localparam logic [5:0]  OFS_CMD        = 6'h19;
    localparam logic [5:0]  OFS_ATTR       = 6'h1a;
    localparam logic [15:0] RX_SEQ_OFS     = 16'h0016;

    // Cluster frame-control fields
    localparam int          FC_TYPE_LSB    = 0;
    localparam int          FC_MFR_BIT     = 2;
    localparam int          FC_DIR_BIT     = 3;
    localparam int          FC_NODEF_BIT   = 4;
    localparam logic [1:0]  FC_TYPE_GEN    = 2'h0;

    // Register byte addresses
    localparam logic [4:0]  REG_CTRL       = 5'h00;
    localparam logic [4:0]  REG_DEST_HI    = 5'h04;
    localparam logic [4:0]  REG_DEST_LO    = 5'h08;
    localparam logic [4:0]  REG_ROUTE      = 5'h0c;
    localparam logic [4:0]  REG_IDS        = 5'h10;
    localparam logic [4:0]  REG_ATTR01     = 5'h14;
    localparam logic [4:0]  REG_ATTR23     = 5'h18;
    localparam logic [4:0]  REG_STATUS     = 5'h1c;

    // Control and status bit positions
    localparam int          CTL_START      = 0;
    localparam int          CTL_EXPLICIT   = 1;
    localparam int          CTL_NWK_UNK    = 2;
    localparam int          ST_BUSY        = 0;
    localparam int          ST_DONE        = 1;
    localparam int          ST_REFUSED     = 2;
    localparam int          ST_RX_OK       = 3;
    localparam int          ST_RX_ERR      = 4;
    localparam int          ST_SEQ_MATCH   = 5;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    // Byte presented on the serial link, with its frame offset
    typedef struct packed {
        logic [7:0] data;
        logic [5:0] pos;
    } ccf_byte_s;

endpackage : ccf_pkg

/* verilog/ccf_frame_host.sv */
// Host controller that builds explicit-transmit read-attribute frames and
// checks the checksum of frames coming back. Assumes one 25 MHz clock, a
// byte stream to the module with valid/ready, and bytes from it with valid.
`timescale 1ns/10ps
`default_nettype none

module ccf_frame_host (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    // Avalon-MM slave
    input  wire logic [4:0]        address_in,
    input  wire logic              read_in,
    input  wire logic              write_in,
    input  wire logic [31:0]       writedata_in,
    output logic      [31:0]       readdata_out,
    output logic                   waitrequest_out,
    // Serial API transmit byte stream
    output ccf_pkg::ccf_byte_s     tx_byte_out,
    output logic                   tx_valid_out,
    input  wire logic              tx_ready_in,
    // Serial API receive byte stream
    input  wire logic [7:0]        rx_data_in,
    input  wire logic              rx_valid_in
);
    import ccf_pkg::*;

    typedef enum logic [1:0] {
        T_IDLE  = 2'b00,
        T_SEND  = 2'b01,
        T_DRAIN = 2'b10
    } ccf_tx_e;

    typedef enum logic [2:0] {
        R_IDLE = 3'b000,
        R_LHI  = 3'b001,
        R_LLO  = 3'b010,
        R_BODY = 3'b011,
        R_CHK  = 3'b100
    } ccf_rx_e;

    function automatic logic [7:0] csum(input logic [7:0] sum);
        csum = CHK_BASE - sum;
    endfunction : csum

    // Registers
    logic [31:0] ctrl_r, ctrl_nxt, dhi_r, dhi_nxt, dlo_r, dlo_nxt;
    logic [31:0] route_r, route_nxt, ids_r, ids_nxt, a01_r, a01_nxt, a23_r, a23_nxt;
    logic [5:0]  flags_r, flags_nxt;
    logic [31:0] readdata_r, readdata_nxt;
    logic        wait_r, wait_nxt;
    logic        acc_w, start_ev, refused_ev, done_ev, rx_ok_ev, rx_err_ev, match_ev;
    logic [7:0]  sent_seq_r, sent_seq_nxt;
    // Transmit
    ccf_tx_e     tx_st_r, tx_st_nxt;
    logic [5:0]  idx_r, idx_nxt;
    logic [7:0]  sum_r, sum_nxt;
    ccf_byte_s   txb_r, txb_nxt;
    logic        txv_r, txv_nxt;
    logic [15:0] tx_len;
    logic [5:0]  chk_pos;
    logic [7:0]  fctl;
    // Receive
    ccf_rx_e     rx_st_r, rx_st_nxt;
    logic [15:0] rlen_r, rlen_nxt, rpos_r, rpos_nxt;
    logic [7:0]  rsum_r, rsum_nxt, rtype_r, rtype_nxt, rseq_r, rseq_nxt;

    // Frame length and checksum position from the attribute count
    assign tx_len  = LEN_BASE + {13'h0000, ctrl_r[4:3], 1'b0} + 16'h0002;
    assign chk_pos = tx_len[5:0] + 6'h03;
    assign fctl    = {3'h0, 1'b0, 1'b0, 1'b0, FC_TYPE_GEN};

    // Byte at a given frame offset
    function automatic logic [7:0] frame_byte(input logic [5:0] i);
        logic [2:0] a;
        a = 3'(i - OFS_ATTR) >> 1;
        frame_byte = 8'h00;
        case (i)
            6'h00: frame_byte = START_DELIM;
            6'h01: frame_byte = tx_len[15:8];
            6'h02: frame_byte = tx_len[7:0];
            6'h03: frame_byte = FT_EXPLICIT_TX;
            6'h04: frame_byte = ctrl_r[15:8];
            6'h05: frame_byte = dhi_r[31:24];
            6'h06: frame_byte = dhi_r[23:16];
            6'h07: frame_byte = dhi_r[15:8];
            6'h08: frame_byte = dhi_r[7:0];
            6'h09: frame_byte = dlo_r[31:24];
            6'h0a: frame_byte = dlo_r[23:16];
            6'h0b: frame_byte = dlo_r[15:8];
            6'h0c: frame_byte = dlo_r[7:0];
            6'h0d: frame_byte = ctrl_r[CTL_NWK_UNK] ? NWK_UNKNOWN[15:8] : route_r[15:8];
            6'h0e: frame_byte = ctrl_r[CTL_NWK_UNK] ? NWK_UNKNOWN[7:0] : route_r[7:0];
            6'h0f: frame_byte = route_r[23:16];
            6'h10: frame_byte = route_r[31:24];
            6'h11: frame_byte = ids_r[15:8];
            6'h12: frame_byte = ids_r[7:0];
            6'h13: frame_byte = ids_r[31:24];
            6'h14: frame_byte = ids_r[23:16];
            6'h15: frame_byte = ctrl_r[31:24];
            6'h16: frame_byte = TX_OPTIONS;
            6'h17: frame_byte = fctl;
            6'h18: frame_byte = ctrl_r[23:16];
            6'h19: frame_byte = CMD_READ_ATTR;
            default: begin
                case (a)
                    3'h0: frame_byte = i[0] ? a01_r[15:8] : a01_r[7:0];
                    3'h1: frame_byte = i[0] ? a01_r[31:24] : a01_r[23:16];
                    3'h2: frame_byte = i[0] ? a23_r[15:8] : a23_r[7:0];
                    default: frame_byte = i[0] ? a23_r[31:24] : a23_r[23:16];
                endcase
            end
        endcase
    endfunction : frame_byte

    // Bus slave and register file next state
    always_comb begin
        ctrl_nxt     = ctrl_r;
        dhi_nxt      = dhi_r;
        dlo_nxt      = dlo_r;
        route_nxt    = route_r;
        ids_nxt      = ids_r;
        a01_nxt      = a01_r;
        a23_nxt      = a23_r;
        flags_nxt    = flags_r;
        readdata_nxt = readdata_r;
        wait_nxt     = 1'b1;
        acc_w        = write_in && !wait_r;
        start_ev     = 1'b0;
        refused_ev   = 1'b0;
        if ((read_in || write_in) && wait_r) begin
            wait_nxt = 1'b0;
            case (address_in)
                REG_CTRL:    readdata_nxt = ctrl_r;
                REG_DEST_HI: readdata_nxt = dhi_r;
                REG_DEST_LO: readdata_nxt = dlo_r;
                REG_ROUTE:   readdata_nxt = route_r;
                REG_IDS:     readdata_nxt = ids_r;
                REG_ATTR01:  readdata_nxt = a01_r;
                REG_ATTR23:  readdata_nxt = a23_r;
                REG_STATUS:  readdata_nxt = {8'h00, rseq_r, rtype_r, 2'b00,
                                             flags_r[5:1], tx_st_r != T_IDLE};
                default:     readdata_nxt = 32'h0000_0000;
            endcase
        end
        if (acc_w) begin
            case (address_in)
                REG_CTRL: begin
                    ctrl_nxt = {writedata_in[31:1], 1'b0};
                    // refuse unless explicit output is selected and the transmit sequencer is idle
                    if (writedata_in[CTL_START]) begin
                        if (writedata_in[CTL_EXPLICIT] && tx_st_r == T_IDLE) begin
                            start_ev = 1'b1;
                        end else begin
                            refused_ev = 1'b1;
                        end
                    end
                end
                REG_DEST_HI: dhi_nxt = writedata_in;
                REG_DEST_LO: dlo_nxt = writedata_in;
                REG_ROUTE:   route_nxt = writedata_in;
                REG_IDS:     ids_nxt = writedata_in;
                REG_ATTR01:  a01_nxt = writedata_in;
                REG_ATTR23:  a23_nxt = writedata_in;
                REG_STATUS:  flags_nxt = flags_r & ~writedata_in[5:0];
                default:     ctrl_nxt = ctrl_r;
            endcase
        end
        // Sticky events win over a clear in the same cycle
        if (done_ev)    flags_nxt[ST_DONE] = 1'b1;
        if (refused_ev) flags_nxt[ST_REFUSED] = 1'b1;
        if (rx_ok_ev)   flags_nxt[ST_RX_OK] = 1'b1;
        if (rx_err_ev)  flags_nxt[ST_RX_ERR] = 1'b1;
        if (match_ev)   flags_nxt[ST_SEQ_MATCH] = 1'b1;
        flags_nxt[ST_BUSY] = 1'b0;
    end

    // Transmit sequencer next state
    always_comb begin
        tx_st_nxt    = tx_st_r;
        idx_nxt      = idx_r;
        sum_nxt      = sum_r;
        txb_nxt      = txb_r;
        txv_nxt      = txv_r;
        sent_seq_nxt = sent_seq_r;
        done_ev      = 1'b0;
        case (tx_st_r)
            T_IDLE: begin
                if (start_ev) begin
                    tx_st_nxt    = T_SEND;
                    idx_nxt      = 6'h00;
                    sum_nxt      = 8'h00;
                    sent_seq_nxt = writedata_in[23:16];
                end
            end
            T_SEND: begin
                if (!txv_r || tx_ready_in) begin
                    txv_nxt     = 1'b1;
                    txb_nxt.pos = idx_r;
                    idx_nxt     = idx_r + 6'h01;
                    if (idx_r == chk_pos) begin
                        txb_nxt.data = csum(sum_r);
                        tx_st_nxt    = T_DRAIN;
                    end else begin
                        txb_nxt.data = frame_byte(idx_r);
                        if (idx_r >= OFS_SUM_FIRST) sum_nxt = sum_r + frame_byte(idx_r);
                    end
                end
            end
            T_DRAIN: begin
                if (tx_ready_in) begin
                    txv_nxt   = 1'b0;
                    tx_st_nxt = T_IDLE;
                    done_ev   = 1'b1;
                end
            end
            default: tx_st_nxt = T_IDLE;
        endcase
    end

    // Receive checker next state
    always_comb begin
        rx_st_nxt = rx_st_r;
        rlen_nxt  = rlen_r;
        rpos_nxt  = rpos_r;
        rsum_nxt  = rsum_r;
        rtype_nxt = rtype_r;
        rseq_nxt  = rseq_r;
        rx_ok_ev  = 1'b0;
        rx_err_ev = 1'b0;
        match_ev  = 1'b0;
        if (rx_valid_in) begin
            case (rx_st_r)
                R_IDLE: if (rx_data_in == START_DELIM) rx_st_nxt = R_LHI;
                R_LHI: begin
                    rlen_nxt[15:8] = rx_data_in;
                    rx_st_nxt      = R_LLO;
                end
                R_LLO: begin
                    rlen_nxt[7:0] = rx_data_in;
                    rpos_nxt      = 16'(OFS_SUM_FIRST);
                    rsum_nxt      = 8'h00;
                    rx_st_nxt     = ({rlen_r[15:8], rx_data_in} == 16'h0000) ? R_IDLE : R_BODY;
                end
                R_BODY: begin
                    rsum_nxt = rsum_r + rx_data_in;
                    rpos_nxt = rpos_r + 16'h0001;
                    if (rpos_r == 16'(OFS_SUM_FIRST)) rtype_nxt = rx_data_in;
                    if (rpos_r == RX_SEQ_OFS) rseq_nxt = rx_data_in;
                    if (rpos_r == rlen_r + 16'h0002) rx_st_nxt = R_CHK;
                end
                R_CHK: begin
                    rx_st_nxt = R_IDLE;
                    if (rx_data_in == csum(rsum_r)) begin
                        rx_ok_ev = 1'b1;
                        match_ev = (rseq_r == sent_seq_r);
                    end else begin
                        rx_err_ev = 1'b1;
                    end
                end
                default: rx_st_nxt = R_IDLE;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ctrl_r <= CTRL_RESET; dhi_r <= '0; dlo_r <= '0; route_r <= '0;
            ids_r <= '0; a01_r <= '0; a23_r <= '0; flags_r <= '0;
            readdata_r <= '0; wait_r <= 1'b1; sent_seq_r <= '0;
            tx_st_r <= T_IDLE; idx_r <= '0; sum_r <= '0; txb_r <= '0; txv_r <= 1'b0;
            rx_st_r <= R_IDLE; rlen_r <= '0; rpos_r <= '0; rsum_r <= '0;
            rtype_r <= '0; rseq_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt; dhi_r <= dhi_nxt; dlo_r <= dlo_nxt; route_r <= route_nxt;
            ids_r <= ids_nxt; a01_r <= a01_nxt; a23_r <= a23_nxt; flags_r <= flags_nxt;
            readdata_r <= readdata_nxt; wait_r <= wait_nxt; sent_seq_r <= sent_seq_nxt;
            tx_st_r <= tx_st_nxt; idx_r <= idx_nxt; sum_r <= sum_nxt; txb_r <= txb_nxt;
            txv_r <= txv_nxt;
            rx_st_r <= rx_st_nxt; rlen_r <= rlen_nxt; rpos_r <= rpos_nxt; rsum_r <= rsum_nxt;
            rtype_r <= rtype_nxt; rseq_r <= rseq_nxt;
        end
    end

    assign readdata_out    = readdata_r;
    assign waitrequest_out = wait_r;
    assign tx_byte_out     = txb_r;
    assign tx_valid_out    = txv_r;

    // Checks on the emitted byte stream and on transmit starts
    property p_chk;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == chk_pos |-> txb_r.data == csum(sum_r);
    endproperty
    a_chk: assert property (p_chk) else $error("bad checksum byte");
    property p_attr;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_ATTR |-> txb_r.data == a01_r[7:0];
    endproperty
    a_attr: assert property (p_attr) else $error("attribute not low byte first");
    property p_fctl;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_FCTL && $past(txb_r.pos) != OFS_FCTL
            |-> $past(txb_r.pos) == OFS_TX_OPT;
    endproperty
    a_fctl: assert property (p_fctl) else $error("frame control misplaced");
    property p_ftype;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_FCTL |-> txb_r.data[FC_TYPE_LSB+:2] == FC_TYPE_GEN;
    endproperty
    a_ftype: assert property (p_ftype) else $error("frame type not general");
    property p_mfr;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_FCTL |-> !txb_r.data[FC_MFR_BIT] && !txb_r.data[FC_DIR_BIT];
    endproperty
    a_mfr: assert property (p_mfr) else $error("mfr or direction bit set");
    property p_resv;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_FCTL |-> txb_r.data[7:FC_NODEF_BIT] == 4'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_seq;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_SEQ |-> txb_r.data == sent_seq_r;
    endproperty
    a_seq: assert property (p_seq) else $error("sequence byte wrong");
    property p_cmd;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_CMD |-> txb_r.data == CMD_READ_ATTR;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not read attributes");
    property p_type;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_SUM_FIRST |-> txb_r.data == FT_EXPLICIT_TX;
    endproperty
    a_type: assert property (p_type) else $error("not explicit frame");
    property p_refuse;
        @(posedge clock_in) disable iff (reset_in)
        tx_st_r == T_IDLE && tx_st_nxt == T_SEND |-> ctrl_nxt[CTL_EXPLICIT];
    endproperty
    a_refuse: assert property (p_refuse) else $error("sent without explicit");
    property p_opt;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_TX_OPT |-> txb_r.data == 8'h00;
    endproperty
    a_opt: assert property (p_opt) else $error("options nonzero");
    property p_nwk;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_NWK_MSB && ctrl_r[CTL_NWK_UNK] |-> txb_r.data == 8'hff;
    endproperty
    a_nwk: assert property (p_nwk) else $error("unknown address wrong");
    property p_len;
        @(posedge clock_in) disable iff (reset_in)
        txv_r && txb_r.pos == OFS_LEN_LO |-> txb_r.data == 8'(chk_pos - 6'h03);
    endproperty
    a_len: assert property (p_len) else $error("length byte wrong");

endmodule : ccf_frame_host

`default_nettype wire

/* verification/ccf_radio_model.sv */
// Behavioural radio module facing the frame host over the serial API link.
// Assumes the host sends bytes with valid/ready; replies when the bench asks.
`timescale 1ns/10ps
`default_nettype none

module ccf_radio_model #(
    parameter int MAX_HOPS = 30  // Network hop limit, plain default
) (
    // Clock, reset and pacing
    input  wire logic               clock_in,
    input  wire logic               reset_in,
    input  wire logic               slow_in,
    // Bytes from the host
    input  wire ccf_pkg::ccf_byte_s tx_byte_in,
    input  wire logic               tx_valid_in,
    output logic                    tx_ready_out,
    // Bytes to the host
    output logic      [7:0]         rx_data_out,
    output logic                    rx_valid_out
);
    import ccf_pkg::*;
    logic [7:0] got_r [0:63];
    int         got_count_r;
    int         hops;

    initial begin
        rx_data_out  = 8'h00;
        rx_valid_out = 1'b0;
    end

    // Take bytes at their offsets; stall every other cycle when slow
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            got_count_r  <= 0;
            tx_ready_out <= 1'b0;
        end else begin
            tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
            if (tx_valid_in && tx_ready_out) begin
                got_r[tx_byte_in.pos] <= tx_byte_in.data;
                got_count_r           <= got_count_r + 1;
            end
        end
    end

    // One byte per edge, then the line shows the inverse of the last byte
    task automatic put(input logic [7:0] b);
        @(posedge clock_in);
        rx_data_out  <= b;
        rx_valid_out <= 1'b1;
    endtask : put

    task automatic send(input logic [7:0] kind, input logic [7:0] seq, input bit bad);
        logic [7:0] body [0:20];
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 21; i++) begin
            body[i] = (i == 0) ? kind : (i == 19) ? seq : 8'(i);
            sum     = sum + body[i];
        end
        put(START_DELIM);
        put(8'h00);
        put(8'h15);
        for (int i = 0; i < 21; i++) begin
            put(body[i]);
        end
        put((CHK_BASE - sum) ^ {7'h00, bad});
        @(posedge clock_in);
        rx_valid_out <= 1'b0;
        rx_data_out  <= ~rx_data_out;
    endtask : send

    // echo sequence, status only for nonzero id, hop radius
    task automatic reply(input bit bad);
        hops = (got_r[21] == 8'h00) ? MAX_HOPS : int'(got_r[21]);
        if (got_r[4] != 8'h00)
            send(8'h8b, ~got_r[24], 1'b0);
        send(8'h91, got_r[24], bad);
    endtask : reply

endmodule : ccf_radio_model
`default_nettype wire

/* verification/ccf_frame_host_tb.sv */
// Self-checking bench for the frame host: registers, frame bytes,
// refusals and reply checking. Assumes the radio model beside it.
`timescale 1ns/10ps
`default_nettype none

module ccf_frame_host_tb;
    import ccf_pkg::*;
    localparam logic [15:0] ATTRS [0:3] = '{16'h0003, 16'h4455, 16'h6677, 16'h8899};
    logic        clock_in     = 1'b0;
    logic        reset_in     = 1'b1;
    logic [4:0]  address_in   = 5'h00;
    logic        read_in      = 1'b0;
    logic        write_in     = 1'b0;
    logic [31:0] writedata_in = 32'h0000_0000;
    logic        slow         = 1'b0;
    logic [31:0] readdata_out;
    logic        waitrequest_out;
    ccf_byte_s   tx_byte;
    logic        tx_valid;
    logic        tx_ready;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic [7:0]  exp_r [0:63];
    logic [31:0] rd;
    int          fail_count   = 0;
    int          tests_run    = 0;

    ccf_frame_host dut_u (.clock_in(clock_in), .reset_in(reset_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .tx_byte_out(tx_byte),
        .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .rx_data_in(rx_data),
        .rx_valid_in(rx_valid));
    ccf_radio_model dev_u (.clock_in(clock_in), .reset_in(reset_in), .slow_in(slow),
        .tx_byte_in(tx_byte), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .rx_data_out(rx_data), .rx_valid_out(rx_valid));

    initial begin
        forever #20 clock_in = ~clock_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("comparisons=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Avalon access held until waitrequest is sampled low
    task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        write_in     <= wr;
        read_in      <= ~wr;
        address_in   <= a;
        writedata_in <= d;
        do begin
            @(posedge clock_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 20);
        rd = readdata_out;
        write_in <= 1'b0;
        read_in  <= 1'b0;
        if (waitrequest_out !== 1'b0) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : bus

    task automatic reset_check;
        bus(0, REG_CTRL, 0);
        chk(rd, CTRL_RESET);
        bus(0, REG_STATUS, 0);
        chk(rd, 32'h0000_0000);
    endtask : reset_check

    // Start without explicit output selected must send nothing
    task automatic refuse_check;
        int base;
        base = dev_u.got_count_r;
        bus(1, REG_CTRL, 32'h0000_0001);
        repeat (8) bus(0, REG_STATUS, 0);
        chk(rd[ST_REFUSED], 1);
        chk(dev_u.got_count_r - base, 0);
        bus(1, REG_STATUS, 32'h0000_0004);
        bus(0, REG_STATUS, 0);
        chk(rd, 32'h0000_0000);
    endtask : refuse_check

    // Send one frame, a refused second start, then check replies
    task automatic frame(input logic [7:0] fid, input logic [7:0] seq, input logic [7:0] rad,
                         input bit unk, input int n, input bit sl);
        int           len;
        int           base;
        int           k;
        logic [7:0]   sum;
        logic [207:0] hdr;
        len  = 23 + 2 * n;
        base = dev_u.got_count_r;
        hdr  = {START_DELIM, 8'h00, 8'(len), FT_EXPLICIT_TX, fid, 64'h0102_0304_0506_0708,
                unk ? NWK_UNKNOWN : 16'h1234, 16'h4142, 16'h0b0c, 16'hd123, rad, 8'h00,
                8'h00, seq, CMD_READ_ATTR};
        sum  = 8'h00;
        for (int i = 0; i < len + 3; i++) begin
            k        = (i - 26) / 2;
            exp_r[i] = (i < 26) ? hdr[8 * (25 - i) +: 8] : ATTRS[k][8 * (i % 2) +: 8];
            if (i >= 3)
                sum = sum + exp_r[i];
        end
        exp_r[len + 3] = CHK_BASE - sum;
        slow <= sl;
        bus(1, REG_CTRL, {rad, seq, fid, 3'h0, 2'(n - 1), unk, 2'h3});
        bus(1, REG_CTRL, {rad, seq, fid, 3'h0, 2'(n - 1), unk, 2'h3});
        bus(0, REG_STATUS, 0);
        chk(rd[ST_BUSY], 1);
        k = 0;
        do begin
            bus(0, REG_STATUS, 0);
            k++;
        end while (rd[ST_DONE] !== 1'b1 && k < 200);
        chk(rd[ST_DONE], 1);
        if (rd[ST_DONE] !== 1'b1)
            tally_and_finish();
        chk(rd[ST_REFUSED], 1);
        chk(dev_u.got_count_r - base, len + 4);
        for (int i = 0; i < len + 4; i++)
            chk(dev_u.got_r[i], exp_r[i]);
        bus(1, REG_STATUS, 32'h0000_003e);
        dev_u.reply(0);
        bus(0, REG_STATUS, 0);
        chk(rd[23:0], {seq, 8'h91, 8'h28});
        bus(1, REG_STATUS, 32'h0000_003e);
        dev_u.reply(1);
        bus(0, REG_STATUS, 0);
        chk(rd[ST_RX_ERR], 1);
        chk(rd[ST_RX_OK], fid != 8'h00);
        chk(rd[ST_SEQ_MATCH], 0);
        bus(1, REG_STATUS, 32'h0000_003e);
    endtask : frame

    initial begin
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        reset_check();
        bus(1, REG_DEST_HI, 32'h0102_0304);
        bus(1, REG_DEST_LO, 32'h0506_0708);
        bus(1, REG_ROUTE, 32'h4241_1234);
        bus(1, REG_IDS, 32'hd123_0b0c);
        bus(1, REG_ATTR01, {ATTRS[1], ATTRS[0]});
        bus(1, REG_ATTR23, {ATTRS[3], ATTRS[2]});
        refuse_check();
        frame(8'h01, 8'h01, 8'h00, 1'b1, 1, 1'b0);
        frame(8'h00, 8'ha5, 8'h07, 1'b0, 4, 1'b1);
        tally_and_finish();
    end

endmodule : ccf_frame_host_tb
`default_nettype wire
